// ---- wdrc_top.sv ----
`timescale 1ns/1ps
module wdrc_top #(
   parameter int unsigned BASE_TIMEOUT_CYCLES = wdrc_pkg::BASE_TIMEOUT
) (
   // APB clock and power-on reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Watchdog oscillator pin
   input  wire logic        wdt_osc_clk,
   // Asynchronous reset sources
   input  wire logic        ext_reset_evt,
   input  wire logic        brownout_evt,
   input  wire logic        debug_reset_evt,
   // System reset request and interrupt
   output logic             wdt_reset_pulse,
   output logic             irq
);

   // Raw asynchronous inputs, one per synchroniser
   logic [3:0]                 async_in;
   logic [3:0]                 sync1_reg;
   logic [3:0]                 sync2_reg;

   // Oscillator and reset event edge detection
   logic                       osc_prev_reg;
   logic                       osc_tick;
   wdrc_pkg::wdrc_rstevt_s     rst_evt;
   wdrc_pkg::wdrc_rstevt_s     rst_prev_reg;
   logic                       rst_rise;

   // APB decode
   logic                       setup_phase;
   logic                       wr_access;
   logic                       hit_known;
   logic [31:0]                rd_value;
   logic [31:0]                prdata_next;
   logic                       pready_next;
   logic                       pslverr_next;
   logic                       wr_cause;
   logic                       wr_ctrl;
   logic                       wr_restart;
   logic                       wr_irq_en;
   logic                       wr_irq_clr;

   // Control register state
   logic                       wde_reg;
   logic                       wde_next;
   logic [2:0]                 sel_reg;
   logic [2:0]                 sel_next;
   logic [2:0]                 toe_cnt_reg;
   logic [2:0]                 toe_cnt_next;
   logic                       toe_bit;
   wdrc_pkg::wdrc_ctrl_s       ctrl_view;

   // Watchdog counter state
   logic [wdrc_pkg::WDT_CNT_W-1:0] cnt_reg;
   logic [wdrc_pkg::WDT_CNT_W-1:0] cnt_next;
   logic [wdrc_pkg::WDT_CNT_W-1:0] limit;
   logic                       expire;
   logic                       pulse_next;
   logic                       pulse_reg;

   // Reset cause flags
   logic [4:0]                 cause_reg;
   logic [4:0]                 cause_next;

   // Interrupt state
   logic [1:0]                 irq_stat_reg;
   logic [1:0]                 irq_stat_next;
   logic [1:0]                 irq_en_reg;
   logic [1:0]                 irq_en_next;
   logic                       irq_reg;
   logic                       irq_next;

   assign async_in = {debug_reset_evt, brownout_evt, ext_reset_evt, wdt_osc_clk};

   // Two-flop synchronisers, one per asynchronous input
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= async_in[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   // Edge detection after the second stage only
   // level crossing, rising edge once
   always_comb begin
      osc_tick = sync2_reg[0] & ~osc_prev_reg;
      rst_evt  = wdrc_pkg::wdrc_rstevt_s'(sync2_reg[3:1]);
      rst_rise = |(rst_evt & ~rst_prev_reg);
   end

   // Previous samples for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_prev_reg <= 1'b0;
         rst_prev_reg <= '0;
      end else begin
         osc_prev_reg <= sync2_reg[0];
         rst_prev_reg <= rst_evt;
      end
   end

   // APB phase and address decode
   always_comb begin
      setup_phase = psel & ~penable;
      // Writes land only at the access edge with ready high
      wr_access   = psel & penable & pready & pwrite;
      wr_cause    = wr_access & (paddr == wdrc_pkg::OFS_RESET_CAUSE);
      wr_ctrl     = wr_access & (paddr == wdrc_pkg::OFS_WDT_CONTROL);
      wr_restart  = wr_access & (paddr == wdrc_pkg::OFS_WDT_RESTART);
      wr_irq_en   = wr_access & (paddr == wdrc_pkg::OFS_IRQ_ENABLE);
      wr_irq_clr  = wr_access & (paddr == wdrc_pkg::OFS_IRQ_CLEAR);
   end

   // Control register as software sees it
   always_comb begin
      toe_bit                   = (toe_cnt_reg != 3'h0);
      ctrl_view.reserved        = 3'h0;
      ctrl_view.turn_off_enable = toe_bit;
      ctrl_view.watchdog_enable = wde_reg;
      ctrl_view.timeout_select  = sel_reg;
   end

   // Read mux, sampled in the setup cycle
   always_comb begin
      rd_value  = 32'h0000_0000;
      hit_known = 1'b1;
      case (paddr)
         wdrc_pkg::OFS_RESET_CAUSE: rd_value[4:0] = cause_reg;
         wdrc_pkg::OFS_WDT_CONTROL: rd_value[7:0] = ctrl_view;
         wdrc_pkg::OFS_IRQ_STATUS:  rd_value[1:0] = irq_stat_reg;
         wdrc_pkg::OFS_IRQ_ENABLE:  rd_value[1:0] = irq_en_reg;
         // Write-only strobe and clear read zero
         wdrc_pkg::OFS_WDT_RESTART, wdrc_pkg::OFS_IRQ_CLEAR: rd_value = 32'h0000_0000;
         default: begin
            hit_known = 1'b0;
         end
      endcase
   end

   // Bus answer: ready in the first access cycle, never a wait state
   always_comb begin
      pready_next  = setup_phase;
      prdata_next  = setup_phase ? rd_value : 32'h0000_0000;
      pslverr_next = setup_phase & ~hit_known;
   end

   // Bus answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= pready_next;
         prdata  <= prdata_next;
         pslverr <= pslverr_next;
      end
   end

   // Control register next state
   always_comb begin
      wde_next     = wde_reg;
      sel_next     = sel_reg;
      toe_cnt_next = toe_cnt_reg;
      if (toe_cnt_reg != 3'h0) begin
         toe_cnt_next = toe_cnt_reg - 3'h1;
      end
      if (wr_ctrl) begin
         sel_next = pwdata[2:0];
         // a one restarts the four-cycle window
         if (pwdata[4]) begin
            toe_cnt_next = wdrc_pkg::TOE_HOLD_CYCLES;
         end
         // set always, clear only inside the window
         if (pwdata[3]) begin
            wde_next = 1'b1;
         end else if (toe_bit) begin
            // second step of the disable sequence
            wde_next = 1'b0;
         end
      end
   end

   // Control register state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wde_reg     <= 1'b0;
         sel_reg     <= wdrc_pkg::RST_TIMEOUT_SEL;
         toe_cnt_reg <= 3'h0;
      end else begin
         wde_reg     <= wde_next;
         sel_reg     <= sel_next;
         toe_cnt_reg <= toe_cnt_next;
      end
   end

   // Watchdog counter next state
   always_comb begin
      // base period doubled per select code
      limit = wdrc_pkg::WDT_CNT_W'(BASE_TIMEOUT_CYCLES) << sel_reg;
      // enabled counter reaching its period
      // At or past the end, so a shorter select never strands the count
      expire     = wde_reg & osc_tick & (cnt_reg >= limit - 1'b1);
      pulse_next = expire;
      cnt_next   = cnt_reg;
      // restart, disable or any chip reset clears it
      if (wr_restart | ~wde_reg | rst_rise | expire | pulse_reg) begin
         cnt_next = '0;
      end else if (osc_tick) begin
         cnt_next = cnt_reg + 1'b1;
      end
   end

   // Watchdog counter and reset pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg   <= '0;
         pulse_reg <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         pulse_reg <= pulse_next;
      end
   end

   assign wdt_reset_pulse = pulse_reg;

   // Reset cause flags: write zero clears, events set, set wins
   always_comb begin
      cause_next = cause_reg;
      if (wr_cause) begin
         // only a software zero clears power-on flag
         cause_next = cause_reg & pwdata[4:0];
      end
      if (rst_evt.debug) begin
         cause_next[wdrc_pkg::POS_DEBUG] = 1'b1;
      end
      if (pulse_reg) begin
         cause_next[wdrc_pkg::POS_WATCHDOG] = 1'b1;
      end
      if (rst_evt.brownout) begin
         cause_next[wdrc_pkg::POS_BROWNOUT] = 1'b1;
      end
      if (rst_evt.external) begin
         cause_next[wdrc_pkg::POS_EXTERNAL] = 1'b1;
      end
   end

   // Power-on reset leaves only the power-on flag set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_reg <= wdrc_pkg::RST_RESET_CAUSE;
      end else begin
         cause_reg <= cause_next;
      end
   end

   // Interrupt status, enable and output
   always_comb begin
      irq_stat_next = irq_stat_reg;
      irq_en_next   = irq_en_reg;
      if (wr_irq_clr) begin
         irq_stat_next = irq_stat_reg & ~pwdata[1:0];
      end
      // Set after clear so a coincident event survives
      if (pulse_reg) begin
         irq_stat_next[wdrc_pkg::POS_IRQ_TIMEOUT] = 1'b1;
      end
      if (rst_rise) begin
         irq_stat_next[wdrc_pkg::POS_IRQ_RSTEVT] = 1'b1;
      end
      if (wr_irq_en) begin
         irq_en_next = pwdata[1:0];
      end
      irq_next = |(irq_stat_next & irq_en_next);
   end

   // Interrupt registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= wdrc_pkg::RST_IRQ;
         irq_en_reg   <= wdrc_pkg::RST_IRQ;
         irq_reg      <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_en_reg   <= irq_en_next;
         irq_reg      <= irq_next;
      end
   end

   assign irq = irq_reg;

endmodule

// ---- wdrc_pkg.sv ----
package wdrc_pkg;

   // Register byte offsets on the APB
   localparam logic [7:0] OFS_RESET_CAUSE = 8'h00;
   localparam logic [7:0] OFS_WDT_CONTROL = 8'h04;
   localparam logic [7:0] OFS_WDT_RESTART = 8'h08;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h0C;
   localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h14;

   // Reset cause flag positions
   localparam int POS_POWERON  = 0;
   localparam int POS_EXTERNAL = 1;
   localparam int POS_BROWNOUT = 2;
   localparam int POS_WATCHDOG = 3;
   localparam int POS_DEBUG    = 4;

   // Interrupt event positions
   localparam int POS_IRQ_TIMEOUT = 0;
   localparam int POS_IRQ_RSTEVT  = 1;

   // Reset values
   localparam logic [4:0] RST_RESET_CAUSE = 5'h01;
   localparam logic [2:0] RST_TIMEOUT_SEL = 3'h0;
   localparam logic [1:0] RST_IRQ         = 2'h0;

   // Timing
   localparam int unsigned OSC_FREQ_HZ     = 1000000;
   localparam int unsigned BASE_TIMEOUT    = 16384;
   localparam logic [2:0]  TOE_HOLD_CYCLES = 3'h4;
   localparam int          WDT_CNT_W       = 22;

   // Watchdog control register layout
   typedef struct packed {
      logic [2:0] reserved;
      logic       turn_off_enable;
      logic       watchdog_enable;
      logic [2:0] timeout_select;
   } wdrc_ctrl_s;

   // External reset events after synchronising
   typedef struct packed {
      logic debug;
      logic brownout;
      logic external;
   } wdrc_rstevt_s;

endpackage

// ---- wdrc_top_monitor.sv ----
`timescale 1ns/1ps
module wdrc_top_monitor #(
   parameter int unsigned BASE_TIMEOUT_CYCLES = 16384
) (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB view
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Reset request
   input wire logic        wdt_reset_pulse
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Setup phase of a transfer
   sequence s_setup;
      psel && !penable;
   endsequence
   // Read answered at one address
   sequence s_rd(a);
      pready && psel && !pwrite && paddr == a;
   endsequence
   // Zero wait states
   property p_ready; s_setup |=> pready && penable; endproperty
   a_ready: assert property (p_ready) else $error("pready late");
   property p_once; pready |=> !pready; endproperty
   a_once: assert property (p_once) else $error("pready held");
   property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
   a_err: assert property (p_err) else $error("bad refusal");
   property p_idle; !pready |-> prdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("prdata not idle");
   // Ticks are at least two cycles apart, so no quick repeat
   property p_pulse; wdt_reset_pulse |=> !wdt_reset_pulse [*7]; endproperty
   a_pulse: assert property (p_pulse) else $error("pulse too long");
   property p_ctrl; s_rd(wdrc_pkg::OFS_WDT_CONTROL) |-> prdata[31:5] == 27'h0; endproperty
   a_ctrl: assert property (p_ctrl) else $error("reserved bits set");
   property p_cause; s_rd(wdrc_pkg::OFS_RESET_CAUSE) |-> prdata[31:5] == 27'h0; endproperty
   a_cause: assert property (p_cause) else $error("cause high bits");
   property p_wr;
      pready && !pwrite && (paddr == wdrc_pkg::OFS_WDT_RESTART ||
         paddr == wdrc_pkg::OFS_IRQ_CLEAR) |-> prdata == 32'h0;
   endproperty
   a_wr: assert property (p_wr) else $error("write-only offset read nonzero");
endmodule
bind wdrc_top wdrc_top_monitor #(.BASE_TIMEOUT_CYCLES(BASE_TIMEOUT_CYCLES)) u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wdt_reset_pulse(wdt_reset_pulse));

// ---- wdrc_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (x)); end end
module wdrc_tb_top;
   // Short base count keeps the run brief
   localparam int unsigned BASE = 4;
   localparam logic [31:0] EXP[3] = '{32'h03, 32'h04, 32'h10};
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdat;
   logic        pready, pslverr, rerr, irq, wdt_reset_pulse;
   logic        wdt_osc_clk = 0, ext_reset_evt = 0, brownout_evt = 0, debug_reset_evt = 0;
   logic [2:0]  osc_div = 0;
   int          err_count = 0, checks = 0, n, lim;
   wdrc_top #(.BASE_TIMEOUT_CYCLES(BASE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .wdt_osc_clk(wdt_osc_clk),
      .ext_reset_evt(ext_reset_evt), .brownout_evt(brownout_evt),
      .debug_reset_evt(debug_reset_evt), .wdt_reset_pulse(wdt_reset_pulse), .irq(irq));
   always #4 pclk = ~pclk;
   // Oscillator stand-in, ten cycles a period, far faster than real
   always @(posedge pclk) begin
      osc_div <= (osc_div == 3'h4) ? 3'h0 : osc_div + 3'h1;
      if (osc_div == 3'h4) wdt_osc_clk <= ~wdt_osc_clk;
   end
   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t pready timeout", $time);
         test_done();
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(rdat, x)
   endtask
   // Bounded wait for the reset request
   task automatic wait_pulse(input int cap);
      n = 0;
      while (wdt_reset_pulse !== 1'b1 && n < cap) begin
         @(posedge pclk);
         n++;
      end
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(8'h00, 32'h01);
      rd(8'h04, 32'h00);
      rd(8'h08, 32'h00);
      rd(8'h14, 32'h00);
      rd(8'h18, 32'h00);
      `CHK(rerr, 1'b1)
      $display("reset values done");
      // Each source sets its own flag and the event interrupt
      wr(8'h10, 32'h2);
      for (int i = 0; i < 3; i++) begin
         {debug_reset_evt, brownout_evt, ext_reset_evt} <= 3'h1 << i;
         repeat (8) @(posedge pclk);
         {debug_reset_evt, brownout_evt, ext_reset_evt} <= 3'h0;
         `CHK(irq, 1'b1)
         rd(8'h00, EXP[i]);
         rd(8'h0C, 32'h2);
         wr(8'h10, 32'h0);
         @(posedge pclk);
         `CHK(irq, 1'b0)
         wr(8'h10, 32'h2);
         @(posedge pclk);
         `CHK(irq, 1'b1)
         wr(8'h14, 32'h2);
         @(posedge pclk);
         `CHK(irq, 1'b0)
         wr(8'h00, 32'h0);
         rd(8'h00, 32'h0);
      end
      $display("reset sources done");
      // Protected disable sequence
      wr(8'h04, 32'hE8);
      rd(8'h04, 32'h08);
      wr(8'h04, 32'h00);
      rd(8'h04, 32'h08);
      wr(8'h04, 32'h18);
      rd(8'h04, 32'h18);
      repeat (4) @(posedge pclk);
      rd(8'h04, 32'h08);
      wr(8'h04, 32'h18);
      wr(8'h04, 32'h00);
      rd(8'h04, 32'h00);
      $display("control done");
      // Every select code, period doubling each step
      for (int s = 0; s < 8; s++) begin
         wr(8'h00, 32'h0);
         wr(8'h04, 32'h08 | s);
         wr(8'h08, 32'h0);
         wait_pulse(8000);
         lim = (BASE << s) * 10;
         `CHK(n >= lim - 10 && n <= lim + 20, 1'b1)
         if (n >= 8000) test_done();
         rd(8'h00, 32'h08);
      end
      $display("timeouts done");
      // Restarts hold off expiry, then disable stops it
      wr(8'h04, 32'h08);
      for (int k = 0; k < 8; k++) begin
         wr(8'h08, 32'h0);
         wait_pulse(15);
         `CHK(n, 15)
      end
      // A rising reset source restarts the count as well
      for (int k = 0; k < 4; k++) begin
         ext_reset_evt <= 1'b1;
         repeat (2) @(posedge pclk);
         ext_reset_evt <= 1'b0;
         wait_pulse(15);
         `CHK(n, 15)
      end
      wr(8'h04, 32'h18);
      wr(8'h04, 32'h00);
      wait_pulse(200);
      `CHK(n, 200)
      $display("restart done");
      test_done();
   end
endmodule
